/* vts_defs.vh */
`ifndef VTS_DEFS_VH
`define VTS_DEFS_VH
// Register byte offsets
`define VTS_REG_CTRL 8'h00
`define VTS_REG_VOUTCMD 8'h04
`define VTS_REG_OVLIM 8'h08
`define VTS_REG_STATUS 8'h0C
`define VTS_REG_IRQSTAT 8'h10
`define VTS_REG_IRQMASK 8'h14
`define VTS_REG_TRACK 8'h18
`define VTS_REG_TARGET 8'h1C
`define VTS_REG_STRAP 8'h20
// CTRL fields
`define VTS_CTRL_SOFTSTOP 0
`define VTS_CTRL_ENABLE 1
`define VTS_CTRL_VOUTSET 2
`define VTS_CTRL_RESET 32'h0000_0000
// IRQ bits
`define VTS_IRQ_CAL 0
`define VTS_IRQ_PGRISE 1
`define VTS_IRQ_PGFALL 2
`define VTS_IRQ_W 3
// Strap threshold in ohms, voltages in mV, 16 bits
`define VTS_STRAP_TRACK_OHM 16'd4220
`define VTS_VOUT_DEFAULT_MV 16'd5250
`define VTS_PG_THRESH_MV 16'd450
`define VTS_STABLE_WIN_MV 16'd100
// Ratio boundaries in mV
`define VTS_B1 16'd990
`define VTS_B2 16'd1120
`define VTS_B3 16'd1280
`define VTS_B4 16'd1500
`define VTS_B5 16'd1820
`define VTS_B6 16'd2290
`define VTS_B7 16'd3120
// Ratio as value x 2^16
`define VTS_R0 17'd65239
`define VTS_R1 17'd57817
`define VTS_R2 17'd50395
`define VTS_R3 17'd42973
`define VTS_R4 17'd35551
`define VTS_R5 17'd28129
`define VTS_R6 17'd20707
`define VTS_R7 17'd13286
// OV default = 112 percent
`define VTS_OV_PCT 8'd112
// Timing
`define VTS_CLK_HZ 10000000
`define VTS_MEAS_MS 10
`define VTS_MEAS_CYC (`VTS_CLK_HZ / 1000 * `VTS_MEAS_MS)
`define VTS_TON_MIN 16'h0000
`endif

/* vts_supervisor.v */
// How it works
// RULE1 - Strap resistance at or below 4.22 kOhm selects tracking mode.
// RULE2 - Tracking target is lesser of tracked level and setpoint level.
// RULE3 - Feedback ratio chosen from setpoint by eight ranges, 0.99547 to 0.20272.
// RULE4 - Undefined setpoint means 5.25 V and ratio 0.20272.
// RULE5 - Host should store and power cycle before changing ratio-affecting setpoint.
// RULE6 - Every 10 ms measure; calibrate above 450 mV after two within 100 mV.
// RULE7 - Power-good asserts when tracking calibration finishes.
// RULE8 - Power-good drops only when a periodic check sees below 450 mV.
// RULE9 - Tracking OV limit defaults to setpoint plus 12 percent until written.
// RULE10 - Undervoltage fault detection disabled while tracking.
// RULE11 - Tracking forces turn-on delay and rise to minimum.
// RULE12 - Soft-stop honoured during tracking; target is lesser of ramp and tracked.
// RULE13 - Soft-stop disabled after reset, enabled only by configuration.
// RULE14 - Ratio latched once at power-up and held until power cycle.
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "vts_defs.vh"
module vts_supervisor (
  input wire clock,
  input wire reset_n,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg wb_ack_o,
  input wire [15:0] strapOhms,
  input wire strapValid,
  input wire [15:0] trackingReferenceInput,
  input wire [15:0] voutMeasured,
  input wire softStopRamp,
  input wire [15:0] softStopLevel,
  input wire calDone,
  output reg calStart,
  output reg [15:0] regTarget,
  output reg [16:0] internalFeedbackRatio,
  output reg [15:0] ovLimit,
  output reg uvEnable,
  output reg [15:0] tonDelay,
  output reg [15:0] tonRise,
  output reg softStopEnable,
  output reg powerGoodOutput,
  output reg trackMode,
  output wire irq
);
  reg [31:0] ctrl_r;
  reg [15:0] voutCmd_r;
  reg voutDef_r;
  reg [15:0] ovUser_r;
  reg ovWritten_r;
  reg [`VTS_IRQ_W-1:0] irqStat_r;
  reg [`VTS_IRQ_W-1:0] irqMask_r;
  reg [15:0] tonDelayCfg_r;
  reg [15:0] tonRiseCfg_r;
  reg initDone_r;
  reg [23:0] measCnt_r;
  reg [15:0] lastMeas_r;
  reg haveMeas_r;
  reg calibrating_r;
  reg calibrated_r;
  reg [15:0] trackLevel;
  reg [15:0] cmdLevel;
  reg [16:0] ratioNxt;
  reg [31:0] quot;
  reg [23:0] ovDef;
  reg [15:0] diff;
  wire acc = wb_cyc_i & wb_stb_i;
  wire wr = acc & wb_we_i & ~wb_ack_o;
  wire tick = (measCnt_r == 24'h000000);
  wire [7:0] adr = wb_adr_i[7:0];
  wire [`VTS_IRQ_W-1:0] evt;
  // Reload kept at 32 bits, then cut to the counter width
  wire [31:0] measReload = `VTS_MEAS_CYC - 1;

  // RULE4 undefined setpoint
  always @* begin
    if (voutDef_r) begin
      cmdLevel = voutCmd_r;
    end else begin
      cmdLevel = `VTS_VOUT_DEFAULT_MV;
    end
  end

  // RULE3 eight ranges
  always @* begin
    if (cmdLevel < `VTS_B1) ratioNxt = `VTS_R0;
    else if (cmdLevel < `VTS_B2) ratioNxt = `VTS_R1;
    else if (cmdLevel < `VTS_B3) ratioNxt = `VTS_R2;
    else if (cmdLevel < `VTS_B4) ratioNxt = `VTS_R3;
    else if (cmdLevel < `VTS_B5) ratioNxt = `VTS_R4;
    else if (cmdLevel < `VTS_B6) ratioNxt = `VTS_R5;
    else if (cmdLevel < `VTS_B7) ratioNxt = `VTS_R6;
    else ratioNxt = `VTS_R7;
  end

  // Input is divider voltage; output = input / ratio
  // Saturates, so a high tracking input cannot wrap the target
  always @* begin
    quot = ({trackingReferenceInput, 16'h0000}) / {15'h0000, internalFeedbackRatio};
    if (quot > 32'h0000FFFF) begin
      trackLevel = 16'hFFFF;
    end else begin
      trackLevel = quot[15:0];
    end
    // 24-bit product: 5250 x 112 does not fit 16 bits
    ovDef = (cmdLevel * `VTS_OV_PCT) / 24'd100;
    // Absolute step between two samples
    if (voutMeasured > lastMeas_r) begin
      diff = voutMeasured - lastMeas_r;
    end else begin
      diff = lastMeas_r - voutMeasured;
    end
  end

  // Events feed the sticky status bits
  assign evt[`VTS_IRQ_CAL] = calibrating_r & calDone;
  assign evt[`VTS_IRQ_PGRISE] = calibrating_r & calDone & ~powerGoodOutput;
  assign evt[`VTS_IRQ_PGFALL] = tick & powerGoodOutput & (voutMeasured < `VTS_PG_THRESH_MV);
  // Level output, no edge to miss
  assign irq = |(irqStat_r & irqMask_r);

  // Wishbone register writes and status
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      // RULE13 soft-stop off
      ctrl_r <= `VTS_CTRL_RESET;
      voutCmd_r <= 16'h0000;
      voutDef_r <= 1'b0;
      ovUser_r <= 16'h0000;
      ovWritten_r <= 1'b0;
      irqStat_r <= {`VTS_IRQ_W{1'b0}};
      irqMask_r <= {`VTS_IRQ_W{1'b0}};
      tonDelayCfg_r <= 16'h0000;
      tonRiseCfg_r <= 16'h0000;
      wb_ack_o <= 1'b0;
    end else begin
      // Ack low for a cycle so a held strobe is not taken twice
      wb_ack_o <= acc & ~wb_ack_o;
      if (wr && wb_sel_i[0]) begin
        case (adr)
          `VTS_REG_CTRL: ctrl_r[7:0] <= wb_dat_i[7:0];
          `VTS_REG_IRQMASK: irqMask_r <= wb_dat_i[`VTS_IRQ_W-1:0];
          default: ;
        endcase
      end
      if (wr && (&wb_sel_i[1:0])) begin
        case (adr)
          `VTS_REG_VOUTCMD: begin
            voutCmd_r <= wb_dat_i[15:0];
            voutDef_r <= 1'b1;
          end
          // RULE9 write overrides default
          `VTS_REG_OVLIM: begin
            ovUser_r <= wb_dat_i[15:0];
            ovWritten_r <= 1'b1;
          end
          `VTS_REG_STRAP: begin
            tonDelayCfg_r <= wb_dat_i[15:0];
            tonRiseCfg_r <= wb_dat_i[31:16];
          end
          default: ;
        endcase
      end
      // Set wins over write-one clear
      if (wr && wb_sel_i[0] && adr == `VTS_REG_IRQSTAT) begin
        irqStat_r <= (irqStat_r & ~wb_dat_i[`VTS_IRQ_W-1:0]) | evt;
      end else begin
        irqStat_r <= irqStat_r | evt;
      end
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      // Read data registered, so it stands with ack
      case (adr)
        `VTS_REG_CTRL: wb_dat_o <= ctrl_r;
        `VTS_REG_VOUTCMD: wb_dat_o <= {15'h0000, voutDef_r, cmdLevel};
        `VTS_REG_OVLIM: wb_dat_o <= {16'h0000, ovLimit};
        `VTS_REG_STATUS: wb_dat_o <= {26'h0000000, uvEnable, calibrated_r, calibrating_r,
          initDone_r, powerGoodOutput, trackMode};
        `VTS_REG_IRQSTAT: wb_dat_o <= {29'h00000000, irqStat_r};
        `VTS_REG_IRQMASK: wb_dat_o <= {29'h00000000, irqMask_r};
        `VTS_REG_TRACK: wb_dat_o <= {15'h0000, internalFeedbackRatio};
        `VTS_REG_TARGET: wb_dat_o <= {16'h0000, regTarget};
        `VTS_REG_STRAP: wb_dat_o <= {tonRiseCfg_r, tonDelayCfg_r};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // Power-up: strap and ratio latched once
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      initDone_r <= 1'b0;
      trackMode <= 1'b0;
      internalFeedbackRatio <= `VTS_R7;
    end else if (!initDone_r && strapValid && ctrl_r[`VTS_CTRL_ENABLE]) begin
      // Waits for a valid strap; later setpoint writes cannot move the ratio
      initDone_r <= 1'b1;
      // RULE1 strap threshold
      trackMode <= (strapOhms <= `VTS_STRAP_TRACK_OHM);
      // RULE14 latch ratio once
      internalFeedbackRatio <= ratioNxt;
    end
  end

  // Measurement tick and calibration
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      measCnt_r <= 24'h000000;
      lastMeas_r <= 16'h0000;
      haveMeas_r <= 1'b0;
      calibrating_r <= 1'b0;
      calibrated_r <= 1'b0;
      calStart <= 1'b0;
      powerGoodOutput <= 1'b0;
    end else begin
      calStart <= 1'b0;
      if (!trackMode) begin
        // Outside tracking, power-good and calibration state are held clear
        measCnt_r <= 24'h000000;
        haveMeas_r <= 1'b0;
        calibrating_r <= 1'b0;
        calibrated_r <= 1'b0;
        powerGoodOutput <= 1'b0;
      end else begin
        // RULE6 10 ms period
        if (tick) begin
          measCnt_r <= measReload[23:0];
        end else begin
          measCnt_r <= measCnt_r - 24'h000001;
        end
        if (tick) begin
          lastMeas_r <= voutMeasured;
          haveMeas_r <= 1'b1;
          // RULE6 stable above threshold
          if (!calibrated_r && !calibrating_r && haveMeas_r &&
              voutMeasured > `VTS_PG_THRESH_MV && diff <= `VTS_STABLE_WIN_MV) begin
            calibrating_r <= 1'b1;
            calStart <= 1'b1;
          end
          // RULE8 periodic low check
          if (voutMeasured < `VTS_PG_THRESH_MV) begin
            powerGoodOutput <= 1'b0;
            calibrated_r <= 1'b0;
          end
        end
        // RULE7 power-good on finish
        if (calibrating_r && calDone) begin
          calibrating_r <= 1'b0;
          calibrated_r <= 1'b1;
          powerGoodOutput <= 1'b1;
        end
      end
    end
  end

  // Protection, soft-start and target
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      regTarget <= 16'h0000;
      ovLimit <= 16'h0000;
      uvEnable <= 1'b0;
      tonDelay <= 16'h0000;
      tonRise <= 16'h0000;
      softStopEnable <= 1'b0;
    end else begin
      // Soft-stop only by a control write
      softStopEnable <= ctrl_r[`VTS_CTRL_SOFTSTOP];
      // Outside tracking only the written limit applies
      if (ovWritten_r || !trackMode) begin
        ovLimit <= ovUser_r;
      end else begin
        // RULE9 default 12 percent
        ovLimit <= (ovDef > 24'h00FFFF) ? 16'hFFFF : ovDef[15:0];
      end
      // RULE10 no UV while tracking
      uvEnable <= ~trackMode;
      if (trackMode) begin
        // RULE11 minimum soft-start
        tonDelay <= `VTS_TON_MIN;
        tonRise <= `VTS_TON_MIN;
      end else begin
        tonDelay <= tonDelayCfg_r;
        tonRise <= tonRiseCfg_r;
      end
      if (!trackMode) begin
        regTarget <= cmdLevel;
      end else if (ctrl_r[`VTS_CTRL_SOFTSTOP] && softStopRamp) begin
        // RULE12 lesser of ramp and tracked
        regTarget <= (softStopLevel < trackLevel) ? softStopLevel : trackLevel;
      end else begin
        // RULE2 lesser of two levels
        regTarget <= (trackLevel < cmdLevel) ? trackLevel : cmdLevel;
      end
    end
  end
endmodule // vts_supervisor

/* vts_sup_monitor.sv */
`timescale 1ns/1ps
`include "vts_defs.vh"
module vts_sup_monitor (
  input wire clock,
  input wire reset_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire wb_ack_o,
  input wire [15:0] voutMeasured,
  input wire calDone,
  input wire calStart,
  input wire [15:0] tonDelay,
  input wire [15:0] tonRise,
  input wire uvEnable,
  input wire softStopEnable,
  input wire powerGoodOutput,
  input wire trackMode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_uv_off: assert property (trackMode && $past(trackMode) |-> !uvEnable)
    else $error("undervoltage detection on while tracking");
  chk_ton_min: assert property (trackMode && $past(trackMode) |-> tonDelay == 16'h0000 && tonRise == 16'h0000)
    else $error("soft-start settings not minimum");
  chk_pg_cause: assert property ($rose(powerGoodOutput) |-> $past(calDone) || $past(calDone, 2))
    else $error("power-good without calibration");
  chk_pg_drop: assert property ($fell(powerGoodOutput) |-> $past(voutMeasured) < `VTS_PG_THRESH_MV || $past(voutMeasured, 2) < `VTS_PG_THRESH_MV)
    else $error("power-good dropped with output high");
  chk_cal_level: assert property (calStart |-> $past(voutMeasured) > `VTS_PG_THRESH_MV ##1 !calStart)
    else $error("calibration start wrong");
  chk_soft_write: assert property ($rose(softStopEnable) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i) || $past(wb_cyc_i && wb_stb_i && wb_we_i, 2))
    else $error("soft-stop enabled without a write");
  cover property (calStart);
  cover property ($rose(powerGoodOutput));
  cover property ($fell(powerGoodOutput));
endmodule // vts_sup_monitor
bind vts_supervisor vts_sup_monitor mon (.*);

/* vts_cal_model.sv */
`timescale 1ns/1ps
module vts_cal_model #(
  parameter int DLY = 20
) (
  input wire clock,
  input wire reset_n,
  input wire calStart,
  output reg calDone
);
  int cnt;
  // Slow answer on purpose: calibration is never instant
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      calDone <= 1'b0;
    end else begin
      calDone <= (cnt == 1);
      if (calStart)
        cnt <= DLY;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule // vts_cal_model

/* tb_voltage_tracking_supervisor.sv */
`timescale 1ns/1ps
`include "vts_defs.vh"
module tb_voltage_tracking_supervisor;
  logic clock = 1'b0;
  logic resetN = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, strapValid = 1'b1, ssRamp = 1'b0;
  logic [31:0] wbAdr = 32'h0, wbDat = 32'h0, rd, ton;
  logic [15:0] strap = 16'd4221, trk = 16'hFFFF, vout = 16'd1000, ssLvl = 16'h0, cmd;
  wire [31:0] wbDatO;
  wire [16:0] ratio;
  wire [15:0] tgt, ovLim, tonD, tonR;
  wire wbAck, calDone, calStart, uvEn, ssEn, pg, trackMode, irq;
  int errors = 0, cmpCount = 0, i;
  vts_supervisor dut (.clock(clock), .reset_n(resetN), .wb_adr_i(wbAdr), .wb_dat_i(wbDat),
    .wb_dat_o(wbDatO), .wb_sel_i(4'hF), .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_ack_o(wbAck), .strapOhms(strap), .strapValid(strapValid),
    .trackingReferenceInput(trk), .voutMeasured(vout), .softStopRamp(ssRamp),
    .softStopLevel(ssLvl), .calDone(calDone), .calStart(calStart), .regTarget(tgt),
    .internalFeedbackRatio(ratio), .ovLimit(ovLim), .uvEnable(uvEn), .tonDelay(tonD),
    .tonRise(tonR), .softStopEnable(ssEn), .powerGoodOutput(pg), .trackMode(trackMode),
    .irq(irq));
  vts_cal_model partner (.clock(clock), .reset_n(resetN), .calStart(calStart),
    .calDone(calDone));
  initial forever #50 clock = ~clock;
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {24'h0, a};
    wbDat <= d;
    do @(posedge clock); while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  function logic [16:0] ratioOf(input logic [15:0] mv);
    if (mv < `VTS_B1) return `VTS_R0;
    if (mv < `VTS_B2) return `VTS_R1;
    if (mv < `VTS_B3) return `VTS_R2;
    if (mv < `VTS_B4) return `VTS_R3;
    if (mv < `VTS_B5) return `VTS_R4;
    if (mv < `VTS_B6) return `VTS_R5;
    if (mv < `VTS_B7) return `VTS_R6;
    return `VTS_R7;
  endfunction
  task wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmpCount, errors);
    if (errors == 0 && cmpCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (260000) @(posedge clock);
    errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(28499));
    cmd = 16'($urandom_range(5000, 600));
    repeat (10) @(posedge clock);
    resetN <= 1'b1;
    ton = $urandom | 32'h0001_0001;
    wb(1'b1, `VTS_REG_STRAP, ton);
    wb(1'b1, `VTS_REG_CTRL, 32'h2);
    repeat (3) @(posedge clock);
    check("tonPass", {tonD, tonR}, {ton[15:0], ton[31:16]});
    check("trackMode", trackMode, 0);
    check("ratio", ratio, `VTS_R7);
    check("uvEnable", uvEn, 1);
    check("softStop", ssEn, 0);
    resetN <= 1'b0;
    strap <= 16'd4220;
    repeat (10) @(posedge clock);
    resetN <= 1'b1;
    wb(1'b1, `VTS_REG_STRAP, ton);
    wb(1'b1, `VTS_REG_VOUTCMD, {16'h0, cmd});
    strapValid <= 1'b0;
    wb(1'b1, `VTS_REG_CTRL, 32'h3);
    repeat (3) @(posedge clock);
    check("initWait", trackMode, 0);
    strapValid <= 1'b1;
    repeat (3) @(posedge clock);
    check("trackMode", trackMode, 1);
    check("ratio", ratio, ratioOf(cmd));
    check("ovLimit", ovLim, cmd * 112 / 100);
    check("tonDelay", {tonD, tonR}, 0);
    check("softStop", ssEn, 1);
    check("target", tgt, cmd);
    // Setpoint moved across a range edge after start-up
    wb(1'b1, `VTS_REG_VOUTCMD, (cmd < 16'd2290) ? 32'd5000 : 32'd600);
    trk <= 16'h0;
    repeat (3) @(posedge clock);
    check("ratioHeld", ratio, ratioOf(cmd));
    wb(1'b0, `VTS_REG_TRACK, 32'h0);
    check("ratioReg", rd, {15'h0, ratioOf(cmd)});
    check("target", tgt, 0);
    trk <= 16'hFFFF;
    ssRamp <= 1'b1;
    ssLvl <= 16'($urandom_range(500, 100));
    repeat (3) @(posedge clock);
    check("softStopTarget", tgt, ssLvl);
    ssRamp <= 1'b0;
    wb(1'b1, `VTS_REG_OVLIM, 32'h1234);
    @(posedge clock);
    check("ovOverride", ovLim, 16'h1234);
    wb(1'b0, 8'h40, 32'h0);
    check("unmapped", rd, 0);
    i = 0;
    while (calStart !== 1'b1 && i < 210000) begin
      @(posedge clock);
      i++;
    end
    check("calSpacing", i > 99000 && calStart === 1'b1, 1);
    repeat (30) @(posedge clock);
    check("pgUp", pg, 1);
    wb(1'b0, `VTS_REG_STATUS, 32'h0);
    check("status", rd, 32'h0000_0017);
    check("irqMasked", irq, 0);
    wb(1'b1, `VTS_REG_IRQMASK, 32'h7);
    @(posedge clock);
    check("irqOn", irq, 1);
    wb(1'b0, `VTS_REG_IRQSTAT, 32'h0);
    check("irqStat", rd, 3);
    wb(1'b1, `VTS_REG_IRQSTAT, 32'h3);
    @(posedge clock);
    check("irqOff", irq, 0);
    vout <= 16'd400;
    i = 0;
    while (pg === 1'b1 && i < 100010) begin
      @(posedge clock);
      i++;
    end
    check("pgDropLag", i > 10 && i <= `VTS_MEAS_CYC, 1);
    wb(1'b0, `VTS_REG_IRQSTAT, 32'h0);
    check("irqFall", rd, 4);
    wrap_up();
  end
endmodule // tb_voltage_tracking_supervisor
